// file: hdl/rfd_core.sv
/*
 * rfd_core: control registers, feedback divider, reference counter and power control.
 * assumes prescaler and reference edges arrive well below half the mclk rate, and that
 * the shift word is stable from the load strobe rising until it has been taken.
 */
`timescale 1ns/1ps
module rfd_core import rfd_pkg::*; #(
	parameter bit WIDE_SWALLOW = 1'b0
) (
	// system clock and reset
	input wire logic mclk,
	input wire logic rst,
	// serial programming port
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic load_strobe,
	// divider inputs
	input wire logic pres_in,
	input wire logic ref_in,
	// divider and pump controls
	output logic pump_hiz,
	output logic synth_pd,
	output logic modulus_high,
	output logic [5:0] prescaler_base,
	output logic div_pulse,
	output logic ref_pulse
);
	// ----------------------------------------
	// link side
	// ----------------------------------------
	logic [23:0] shift_word;

	rfd_link_shift u_link (
		.ser_clk(ser_clk),
		.rst(rst),
		.ser_data(ser_data),
		.shift_word(shift_word)
	);

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	rfd_core_state_s q_reg;
	rfd_core_state_s q_next;
	logic ld_rise;
	logic pres_rise;
	logic ref_rise;
	logic [4:0] swallow_val;
	logic [14:0] main_val;
	logic [14:0] ref_val;
	logic clr;
	logic run;

	assign ld_rise = q_reg.sync2[0] & ~q_reg.sync3[0];
	assign pres_rise = q_reg.sync2[1] & ~q_reg.sync3[1];
	assign ref_rise = q_reg.sync2[2] & ~q_reg.sync3[2];
	assign ref_val = q_reg.ref_word[FIELD_LSB +: REF_W];
	assign clr = q_reg.ref_word[CLR_BIT];
	// a powered-down divider is held just like a cleared one
	assign run = ~clr & ~q_reg.pd_active;

	generate
		if (WIDE_SWALLOW) begin : g_wide
			assign swallow_val = q_reg.fb_word[WIDE_SWALLOW_MSB:FIELD_LSB];
			assign main_val = {1'b0, q_reg.fb_word[MAIN_MSB:WIDE_SWALLOW_MSB + 1]};
		end else begin : g_narrow
			assign swallow_val = {1'b0, q_reg.fb_word[NARROW_SWALLOW_MSB:FIELD_LSB]};
			assign main_val = q_reg.fb_word[MAIN_MSB:NARROW_SWALLOW_MSB + 1];
		end
	endgenerate

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		q_next = q_reg;
		// the first stage feeds only the second; edges are read between stages two and three
		q_next.sync1 = {ref_in, pres_in, load_strobe};
		q_next.sync2 = q_reg.sync1;
		q_next.sync3 = q_reg.sync2;
		q_next.div_pulse = 1'b0;
		q_next.ref_pulse = 1'b0;
		// the host has stopped the serial clock by now, so the word is quiet while taken
		if (ld_rise) begin
			case (shift_word[ADDR_W - 1:0])
				ADDR_REF: q_next.ref_word = shift_word;
				ADDR_FB: q_next.fb_word = shift_word;
				default: ;
			endcase
		end
		// tri-state follows the word in the very update that stores it
		q_next.pump_hiz = q_next.ref_word[HIZ_BIT];
		if (!run) begin
			// all three counters wait preloaded, so they leave the clear in step
			q_next.swallow_cnt = swallow_val;
			q_next.main_cnt = main_val;
			q_next.ref_cnt = ref_val;
		end else begin
			if (pres_rise) begin
				if (q_reg.swallow_cnt != 5'h00) begin
					q_next.swallow_cnt = q_reg.swallow_cnt - 5'h01;
				end
				if (q_reg.main_cnt <= 15'h0001) begin
					q_next.main_cnt = main_val;
					q_next.swallow_cnt = swallow_val;
					q_next.div_pulse = 1'b1;
				end else begin
					q_next.main_cnt = q_reg.main_cnt - 15'h0001;
				end
			end
			if (ref_rise) begin
				if (q_reg.ref_cnt <= 15'h0001) begin
					q_next.ref_cnt = ref_val;
					q_next.ref_pulse = 1'b1;
				end else begin
					q_next.ref_cnt = q_reg.ref_cnt - 15'h0001;
				end
			end
		end
		q_next.modulus_high = (q_next.swallow_cnt != 5'h00);
		// tri-state set: stop at once; clear: stop at the next phase-detector event
		if (!q_reg.fb_word[PD_BIT]) begin
			q_next.pd_active = 1'b0;
		end else if (q_reg.ref_word[HIZ_BIT] || q_next.ref_pulse) begin
			q_next.pd_active = 1'b1;
		end
		if (WIDE_SWALLOW) begin
			q_next.base = q_reg.fb_word[PSEL_BIT] ? WIDE_BASE_HI : WIDE_BASE_LO;
		end else begin
			q_next.base = q_reg.fb_word[PSEL_BIT] ? NARROW_BASE_HI : NARROW_BASE_LO;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q_reg <= '0;
			q_reg.ref_word <= REF_WORD_RESET;
			q_reg.fb_word <= FB_WORD_RESET;
			q_reg.pd_active <= 1'b1;
			q_reg.base <= WIDE_SWALLOW ? WIDE_BASE_LO : NARROW_BASE_LO;
		end else begin
			q_reg <= q_next;
		end
	end

	assign pump_hiz = q_reg.pump_hiz;
	assign synth_pd = q_reg.pd_active;
	assign modulus_high = q_reg.modulus_high;
	assign prescaler_base = q_reg.base;
	assign div_pulse = q_reg.div_pulse;
	assign ref_pulse = q_reg.ref_pulse;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_hiz_level_match: assert property ($changed(pump_hiz) |->
		$past(ld_rise && shift_word[2:0] == ADDR_REF))
		else $error("pump tri-state moved without a reference word load");
	a_hiz_load_now: assert property (ld_rise && shift_word[2:0] == ADDR_REF |=>
		pump_hiz == $past(shift_word[HIZ_BIT]))
		else $error("pump tri-state not applied in the load cycle");
	a_async_pd_now: assert property (q_reg.fb_word[PD_BIT] && q_reg.ref_word[HIZ_BIT] |=> synth_pd)
		else $error("asynchronous power-down late");
	a_sync_pd_event: assert property ($rose(synth_pd) && !$past(q_reg.ref_word[HIZ_BIT]) |-> ref_pulse)
		else $error("synchronous power-down off a phase-detector event");
	a_clear_holds_div: assert property (clr ##1 clr |-> !div_pulse && !ref_pulse)
		else $error("counter moved during clear");
	a_clear_release_aligned: assert property ($fell(clr) && !synth_pd |->
		q_reg.main_cnt == main_val && q_reg.ref_cnt == ref_val && q_reg.swallow_cnt == swallow_val)
		else $error("counters not aligned at clear release");
	a_word_routing: assert property (ld_rise && shift_word[2:0] == ADDR_FB |=>
		q_reg.fb_word == $past(shift_word))
		else $error("feedback word not taken");
	a_main_reload: assert property (run && pres_rise && q_reg.main_cnt == 15'h0001 |=> div_pulse)
		else $error("divider did not wrap");
	a_modulus_swallow: assert property (run && pres_rise && q_reg.swallow_cnt == 5'h01 &&
		q_reg.main_cnt > 15'h0001 |=> !modulus_high)
		else $error("modulus does not drop after the swallow count");
	a_base_select: assert property (##1 prescaler_base == (WIDE_SWALLOW ?
		($past(q_reg.fb_word[PSEL_BIT]) ? WIDE_BASE_HI : WIDE_BASE_LO) :
		($past(q_reg.fb_word[PSEL_BIT]) ? NARROW_BASE_HI : NARROW_BASE_LO)))
		else $error("prescaler ratio wrong");
	a_pd_release: assert property (!q_reg.fb_word[PD_BIT] |=> !synth_pd)
		else $error("power-up late");

	c_div_wrap: cover property (run && div_pulse);
	c_sync_pd: cover property ($rose(synth_pd) && ref_pulse);
	c_clear_release: cover property ($fell(clr));
	c_swallow_active: cover property (run && modulus_high ##[1:200] !modulus_high);
endmodule

// file: hdl/rfd_link_shift.sv
/*
 * rfd_link_shift: the serial shift register, clocked by the host's serial clock.
 * assumes the host holds the serial clock still while the load strobe is high.
 */
`timescale 1ns/1ps
module rfd_link_shift import rfd_pkg::*; (
	// link clock and reset
	input wire logic ser_clk,
	input wire logic rst,
	// serial data
	input wire logic ser_data,
	// assembled word
	output logic [23:0] shift_word
);
	rfd_link_state_s q_reg;
	rfd_link_state_s q_next;

	always_comb begin
		q_next = q_reg;
		q_next.sh = {q_reg.sh[22:0], ser_data};
	end

	always_ff @(posedge ser_clk or posedge rst) begin
		if (rst) begin
			q_reg.sh <= SHIFT_RESET;
		end else begin
			q_reg <= q_next;
		end
	end

	assign shift_word = q_reg.sh;
endmodule

// file: hdl/rfd_pkg.sv
/*
 * rfd_pkg: constants and carrier types for the rf feedback divider control block.
 * assumes a 24-bit serial control word, with the register address in its low three bits.
 */
// Overview of operation
// - the pump output is high impedance while the pump tri-state bit (reference word bit 20) is 1, normal while 0.
// - a change of the pump tri-state bit takes effect at once, with no wait for any counter event.
// - pump tri-state together with power-down selects asynchronous (tri-state 1) or synchronous power-down.
// - reference word bit 21 holds the swallow, main and reference counters in reset while 1.
// - on release of the counter clear, swallow and main counters restart aligned with the reference counter.
// - swallow count, main count, prescaler select and power-down come from the feedback word.
// - narrow variant: the swallow count is 4 bits at feedback word bits 6..3, values 0 to 15.
// - wide variant: the swallow count is 5 bits at feedback word bits 7..3, values 0 to 31.
// - narrow variant: the main count is 15 bits at bits 21..7, 3 to 32767; the host never writes below 3.
// - wide variant: the main count is 14 bits at bits 21..8, 3 to 16383; the host never writes below 3.
// - narrow variant: prescaler select 0 gives 8/9, 1 gives 16/17.
// - wide variant: prescaler select 0 gives 16/17, 1 gives 32/33.
// - the host shifts 24 bits msb first; the word is transferred on the rising load strobe.
// - word bits 2..0 address the target: 000 reference word, 001 feedback word.
// - feedback word bit 23 powers the synthesizer down while 1 and keeps it active while 0.
package rfd_pkg;
	localparam int WORD_W = 24;
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_REF = 3'h0;
	localparam logic [2:0] ADDR_FB = 3'h1;
	localparam int HIZ_BIT = 20;
	localparam int CLR_BIT = 21;
	localparam int PSEL_BIT = 22;
	localparam int PD_BIT = 23;
	localparam int FIELD_LSB = 3;
	localparam int REF_W = 15;
	localparam int SWALLOW_W = 5;
	localparam int MAIN_W = 15;
	localparam int MAIN_MSB = 21;
	localparam int NARROW_SWALLOW_MSB = 6;
	localparam int WIDE_SWALLOW_MSB = 7;
	localparam int BASE_W = 6;
	localparam logic [5:0] NARROW_BASE_LO = 6'h08;
	localparam logic [5:0] NARROW_BASE_HI = 6'h10;
	localparam logic [5:0] WIDE_BASE_LO = 6'h10;
	localparam logic [5:0] WIDE_BASE_HI = 6'h20;
	localparam logic [23:0] REF_WORD_RESET = 24'h000000;
	localparam logic [23:0] FB_WORD_RESET = 24'h800001;
	localparam logic [23:0] SHIFT_RESET = 24'h000000;
	localparam int SYNC_W = 3;

	typedef struct packed {
		logic [23:0] sh;
	} rfd_link_state_s;

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] sync3;
		logic [23:0] ref_word;
		logic [23:0] fb_word;
		logic [4:0] swallow_cnt;
		logic [14:0] main_cnt;
		logic [14:0] ref_cnt;
		logic pd_active;
		logic pump_hiz;
		logic modulus_high;
		logic div_pulse;
		logic ref_pulse;
		logic [5:0] base;
	} rfd_core_state_s;
endpackage

// file: testbench/rfd_core_tb.sv
/*
 * rfd_core_tb: self-checking bench for both variants of the feedback divider control, side by side.
 * assumes a 40 MHz mclk and the behavioural host model on the serial port.
 */
`timescale 1ns/1ps
module rfd_core_tb;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic pres_in = 1'b0;
	logic ref_in = 1'b0;
	logic ser_clk, ser_data, load_strobe;
	logic pump_hiz, synth_pd, modulus_high, div_pulse, ref_pulse;
	logic [5:0] prescaler_base;
	logic w_hiz, w_pd, w_mod, w_div;
	logic [5:0] w_base;
	int n_fail = 0;
	int comparisons = 0;
	int n_div = 0;
	int n_ref = 0;
	int n_div_w = 0;

	// ----------------------------------------
	// instances and clock
	// ----------------------------------------
	rfd_core #(.WIDE_SWALLOW(1'b0)) u_rfd_core (.mclk(mclk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
		.load_strobe(load_strobe), .pres_in(pres_in), .ref_in(ref_in), .pump_hiz(pump_hiz), .synth_pd(synth_pd),
		.modulus_high(modulus_high), .prescaler_base(prescaler_base), .div_pulse(div_pulse), .ref_pulse(ref_pulse));
	// wide variant hears every word; only its own scenario and the prescaler select scenario judge it
	rfd_core #(.WIDE_SWALLOW(1'b1)) u_rfd_core_wide (.mclk(mclk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data),
		.load_strobe(load_strobe), .pres_in(pres_in), .ref_in(ref_in), .pump_hiz(w_hiz), .synth_pd(w_pd),
		.modulus_high(w_mod), .prescaler_base(w_base), .div_pulse(w_div), .ref_pulse());
	rfd_host_model u_rfd_host_model (.ser_clk(ser_clk), .ser_data(ser_data), .load_strobe(load_strobe));

	initial begin
		forever #12.5 mclk = ~mclk;
	end

	// counted on the falling edge, away from the edge that launches the pulses
	always @(negedge mclk) begin
		if (div_pulse === 1'b1)
			n_div <= n_div + 1;
		if (ref_pulse === 1'b1)
			n_ref <= n_ref + 1;
		if (w_div === 1'b1)
			n_div_w <= n_div_w + 1;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [23:0] w0(input logic clr, input logic hiz);
		return {2'b00, clr, hiz, 2'b00, 15'h0003, 3'h0};
	endfunction

	// main count kept at 3 or more by every caller
	function automatic logic [23:0] w1(input logic pd, input logic psel, input logic [14:0] mc, input logic [3:0] sw);
		return {pd, psel, mc, sw, 3'h1};
	endfunction

	task automatic wr(input logic [23:0] w);
		u_rfd_host_model.send(w);
		repeat (6) @(negedge mclk);
	endtask

	// slow edges, then room for the two-flop synchroniser to land
	task automatic edges(input int n, input logic on_ref);
		repeat (n) begin
			@(negedge mclk);
			if (on_ref) ref_in = 1'b1; else pres_in = 1'b1;
			repeat (3) @(negedge mclk);
			if (on_ref) ref_in = 1'b0; else pres_in = 1'b0;
			repeat (3) @(negedge mclk);
		end
		repeat (3) @(negedge mclk);
	endtask

	task automatic final_report();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_and_hiz();
		check(24'(synth_pd), 24'h1);
		check(24'(prescaler_base), 24'h8);
		check(24'(pump_hiz), 24'h0);
		u_rfd_host_model.send(w0(1'b0, 1'b1));
		check(24'(pump_hiz), 24'h1);
		wr(w0(1'b0, 1'b0));
		check(24'(pump_hiz), 24'h0);
	endtask

	task automatic t_prescaler_select();
		for (int p = 0; p < 2; p++) begin
			wr(w1(1'b0, p[0], 15'h0003, 4'h2));
			check(24'(prescaler_base), p[0] ? 24'h10 : 24'h8);
			check(24'(w_base), p[0] ? 24'h20 : 24'h10);
			check(24'(synth_pd), 24'h0);
		end
	endtask

	task automatic t_clear_and_divide();
		int d;
		int r;
		wr(w0(1'b1, 1'b0));
		d = n_div;
		r = n_ref;
		edges(4, 1'b0);
		check(24'(n_div - d), 24'h0);
		edges(3, 1'b1);
		check(24'(n_ref - r), 24'h0);
		check(24'(modulus_high), 24'h1);
		wr(w0(1'b0, 1'b0));
		edges(2, 1'b0);
		check(24'(modulus_high), 24'h0);
		edges(1, 1'b0);
		check(24'(n_div - d), 24'h1);
		check(24'(modulus_high), 24'h1);
		// swallow at its top value, odd main count so bit 7 must belong to main
		wr(w1(1'b0, 1'b0, 15'h0011, 4'hf));
		wr(w0(1'b1, 1'b0));
		wr(w0(1'b0, 1'b0));
		d = n_div;
		edges(14, 1'b0);
		check(24'(modulus_high), 24'h1);
		edges(1, 1'b0);
		check(24'(modulus_high), 24'h0);
		edges(1, 1'b0);
		check(24'(n_div - d), 24'h0);
		edges(1, 1'b0);
		check(24'(n_div - d), 24'h1);
	endtask

	task automatic t_unmapped_and_powerdown();
		int r;
		wr(24'hfffffa);
		check(24'(pump_hiz), 24'h0);
		check(24'(synth_pd), 24'h0);
		wr(w1(1'b1, 1'b0, 15'h0003, 4'h0));
		check(24'(synth_pd), 24'h0);
		r = n_ref;
		edges(3, 1'b1);
		check(24'(n_ref - r), 24'h1);
		check(24'(synth_pd), 24'h1);
		wr(w1(1'b0, 1'b0, 15'h0003, 4'h0));
		check(24'(synth_pd), 24'h0);
		wr(w0(1'b0, 1'b1));
		wr(w1(1'b1, 1'b0, 15'h0003, 4'h0));
		check(24'(synth_pd), 24'h1);
	endtask

	// wide layout: main 20 at bits 21..8, swallow 17 so bit 7 must belong to swallow
	task automatic t_wide_variant();
		int d;
		wr({2'b01, 14'h0014, 5'h11, 3'h1});
		check(24'(w_base), 24'h20);
		check(24'(prescaler_base), 24'h10);
		wr(w0(1'b1, 1'b0));
		wr(w0(1'b0, 1'b0));
		check(24'(w_pd), 24'h0);
		check(24'(w_hiz), 24'h0);
		d = n_div_w;
		edges(16, 1'b0);
		check(24'(w_mod), 24'h1);
		edges(1, 1'b0);
		check(24'(w_mod), 24'h0);
		edges(2, 1'b0);
		check(24'(n_div_w - d), 24'h0);
		edges(1, 1'b0);
		check(24'(n_div_w - d), 24'h1);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		t_reset_and_hiz();
		t_prescaler_select();
		t_clear_and_divide();
		t_unmapped_and_powerdown();
		t_wide_variant();
		final_report();
	end

	// whole run is roughly 30 us; about eight times that is a hang
	initial begin
		#250000;
		n_fail++;
		final_report();
	end
endmodule

// file: testbench/rfd_host_model.sv
/*
 * rfd_host_model: behavioural host that shifts control words into the serial programming port.
 * assumes the bench calls send() only after reset is released, one word at a time.
 */
`timescale 1ns/1ps
module rfd_host_model (
	// serial programming port
	output logic ser_clk,
	output logic ser_data,
	output logic load_strobe
);
	// serial clock stands still between words; data toggles off so stale bits never look valid
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b1;
		load_strobe = 1'b0;
	end

	// 32 ns link period, msb first, exactly 24 rises then the strobe
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			ser_data = w[i];
			#16 ser_clk = 1'b1;
			#16 ser_clk = 1'b0;
		end
		ser_data = ~w[0];
		// strobe held six mclk with the word frozen, then low well over three mclk
		#16 load_strobe = 1'b1;
		#150 load_strobe = 1'b0;
		#100;
	endtask
endmodule
